// *** teletext_router.sv ***
`timescale 1ns/1ps
`include "teletext_router_map.svh"
// Function
// - A line carrying a teletext packet outputs teletext, ignoring that line's pixels.
// - The 16-bit clock run-in is generated internally before the payload bits.
// - System B teletext: one at 66 IRE, zero at 0 IRE, 200 ns raised-cosine edges.
// - System C teletext: one at 70 IRE, zero at 0 IRE, 200 ns raised-cosine edges.
// - Teletext packet: 00 FF FF, ID 110100, block 1, count, 86 nibbles, two zeros, check.
// - First payload word bit P13 selects 525 (0) or 625 (1) lines.
// - First payload word bit P12 selects system B (0) or system C (1).
// - 625-line B sends 43 bytes; 525-line B sends 35, skipping bits 343-280.
// - 525-line C sends 34 bytes, skipping bits 343-272.
// - Parity bits of every word and the check word are ignored.
// - Phase packet: ID 110101, block 1, 4 line-rate nibbles, 8 subcarrier nibbles, MSB first.
// - Line-rate increment and the three flag bits are ignored.
// - Four 10-bit DAC channels update at the double-rate clock.
// - Y/C mode: luma, chroma and two composites, all time aligned.
// - RGB mode converts YCbCr per standard, optional sync on green, no VBI data.
// - RGB, compat clear: composite first pin, red second, blue chroma, green luma.
// - RGB, compat set: composite luma, red chroma, blue second, green first pin.
// - YUV clamps below 16, shared CbCr scale, separate Y scale, NTSC/PAL sets.
// - YUV: Y carries VBI and optional sync; composite luma, V chroma, Y first, U second.
// - Every DAC channel has its own independent enable.
// - Power-down zeroes all DACs and freezes the pipeline; controls stay usable.
// - Reset on power-up, pin low four cycles, or soft reset; control port goes idle.

module anc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_st_t;
    fifo_st_t q, d;
    logic push, pop;

    assign in_ready = q.cnt != FULL;
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module teletext_router import teletext_router_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reset_pin_n,
    input wire logic soft_reset,
    input wire logic power_down,
    input wire logic [3:0] dac_en,
    input wire logic [1:0] out_mode,
    input wire logic connector_compat_bit,
    input wire logic pal_mode,
    input wire logic add_sync,
    input wire logic sync_tip,
    input wire logic [7:0] anc_word,
    input wire logic anc_valid,
    output logic anc_ready,
    input wire logic sav_pulse,
    input wire logic pix_valid,
    input wire logic [7:0] y_in,
    input wire logic [7:0] cb_in,
    input wire logic [7:0] cr_in,
    input wire logic [9:0] chroma_in,
    output logic [9:0] luma_pin,
    output logic [9:0] chroma_pin,
    output logic [9:0] first_composite_pin,
    output logic [9:0] second_composite_pin,
    output logic ttx_on,
    output logic [31:0] subcarrier_increment,
    output logic subcarrier_inc_valid,
    output logic ctrl_if_active
);
    core_st_t q, d;
    logic [7:0] w;
    logic w_valid, w_take, int_rst, nbit;
    logic [9:0] lvl, hi, comp_v;
    logic [17:0] prod;
    logic [9:0] rt [4];
    logic [9:0] gated [4];

    function automatic logic [7:0] cos_tab(input logic [2:0] i);
        case (i)
            3'h0: cos_tab = 8'h02;
            3'h1: cos_tab = 8'h16;
            3'h2: cos_tab = 8'h39;
            3'h3: cos_tab = 8'h67;
            3'h4: cos_tab = 8'h99;
            3'h5: cos_tab = 8'hc7;
            3'h6: cos_tab = 8'hea;
            default: cos_tab = 8'hfe;
        endcase
    endfunction

    function automatic logic [9:0] sat10(input logic signed [13:0] v);
        if (v < 14'sh0000) begin
            sat10 = 10'h000;
        end else if (v > 14'sh03ff) begin
            sat10 = 10'h3ff;
        end else begin
            sat10 = v[9:0];
        end
    endfunction

    function automatic logic signed [13:0] wide(input logic [7:0] x);
        wide = $signed({4'h0, x, 2'b00});
    endfunction

    // Absorbs bursts while the parser is held by power-down or reset
    anc_fifo #(.W(8), .D(8)) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(anc_word),
        .in_valid(anc_valid),
        .in_ready(anc_ready),
        .out_data(w),
        .out_valid(w_valid),
        .out_ready(w_take)
    );

    assign int_rst = (q.rst_cnt == `RST_PIN_CYC) || soft_reset;
    assign w_take = !power_down && !int_rst;
    assign hi = q.lat_sys ? `TTX_HI_C : `TTX_HI_B;
    assign prod = (hi - `TTX_LO) * cos_tab(3'(q.pos / 6'(`TTX_STEP_CYC)));
    // Ends are pinned so settled levels are exact; the table alone stops a few codes short
    assign lvl = (q.pos == 6'h0) ? `TTX_LO : (q.pos == 6'(`TTX_EDGE_CYC - 1)) ? hi
        : 10'(`TTX_LO + prod[17:8]);
    assign ttx_on = q.sst != S_IDLE;

    always_comb begin
        case (q.sst)
            S_RUNIN: nbit = 1'(`RUNIN_PAT >> q.bit_cnt[3:0]);
            S_DATA: nbit = q.play[q.bit_cnt];
            default: nbit = 1'b0;
        endcase
    end

    // Source picture for each of the four channels
    always_comb begin
        logic signed [13:0] y10, cb10, cr10, comp, r, g, b, yv, uv, vv;
        logic [7:0] yc, cbc, crc;
        logic [9:0] luma_v, chroma_v, g_v, yv_v;
        y10 = wide(q.y_r);
        cb10 = wide(q.cb_r) - `CHROMA_ZERO;
        cr10 = wide(q.cr_r) - `CHROMA_ZERO;
        comp = y10 + $signed({4'h0, q.chroma_r}) - `CHROMA_ZERO;
        luma_v = ttx_on ? lvl : {q.y_r, 2'b00};
        chroma_v = ttx_on ? 10'(`CHROMA_ZERO) : q.chroma_r;
        comp_v = ttx_on ? lvl : sat10(comp);
        // shift-add matrix, PAL terms slightly larger
        r = y10 + cr10 + (cr10 >>> 2) + (cr10 >>> 3) + (pal_mode ? (cr10 >>> 4) : 14'sh0);
        g = y10 - (cr10 >>> 1) - (cb10 >>> 2);
        b = y10 + cb10 + (cb10 >>> 1) + (cb10 >>> 2) + (pal_mode ? (cb10 >>> 4) : 14'sh0);
        g_v = (out_mode == M_RGB_SOG && q.sync_r) ? 10'h000 : sat10(g);
        // clamp, then one scale for CbCr and another for Y
        yc = (q.y_r < `CLAMP_MIN) ? `CLAMP_MIN : q.y_r;
        cbc = (q.cb_r < `CLAMP_MIN) ? `CLAMP_MIN : q.cb_r;
        crc = (q.cr_r < `CLAMP_MIN) ? `CLAMP_MIN : q.cr_r;
        yv = wide(yc) - (wide(yc) >>> (pal_mode ? 4 : 3));
        uv = wide(cbc) - (wide(cbc) >>> (pal_mode ? 3 : 2));
        vv = wide(crc) - (wide(crc) >>> (pal_mode ? 3 : 2));
        yv_v = ttx_on ? lvl : sat10(yv);
        if (add_sync && q.sync_r) begin
            yv_v = 10'h000;
        end
        case (out_mode)
            M_YC: begin
                rt[0] = luma_v;
                rt[1] = chroma_v;
                rt[2] = comp_v;
                rt[3] = comp_v;
            end
            M_YUV: begin
                rt[0] = comp_v;
                rt[1] = sat10(vv);
                rt[2] = yv_v;
                rt[3] = sat10(uv);
            end
            default: begin
                if (!connector_compat_bit) begin
                    rt[0] = g_v;
                    rt[1] = sat10(b);
                    rt[2] = comp_v;
                    rt[3] = sat10(r);
                end else begin
                    rt[0] = comp_v;
                    rt[1] = sat10(r);
                    rt[2] = g_v;
                    rt[3] = sat10(b);
                end
            end
        endcase
    end

    for (genvar gi = 0; gi < 4; gi++) begin : g_dac
        assign gated[gi] = dac_en[gi] ? rt[gi] : 10'h000;
    end

    always_comb begin
        logic s1, s2;
        logic [2:0] cnt;
        s1 = 1'b0;
        s2 = 1'b0;
        cnt = 3'h0;
        d = q;
        d.rst_s1 = reset_pin_n;
        d.rst_s2 = q.rst_s1;
        if (q.rst_s2) begin
            d.rst_cnt = 3'h0;
        end else if (q.rst_cnt != `RST_PIN_CYC) begin
            d.rst_cnt = q.rst_cnt + 3'h1;
        end
        d.ctrl_active = !int_rst;
        d.sub_vld = 1'b0;

        // Serialiser first, so a packet finishing this cycle still sets pend
        case (q.sst)
            S_IDLE: begin
                if (sav_pulse && q.pend) begin
                    d.pend = 1'b0;
                    d.play = q.load;
                    d.lat_sys = q.ld_sys;
                    d.bit_per = q.ld_sys ? 6'(`TTX_BIT_C_CYC) : 6'(`TTX_BIT_B_CYC);
                    d.bit_tmr = (q.ld_sys ? 6'(`TTX_BIT_C_CYC) : 6'(`TTX_BIT_B_CYC)) - 6'h1;
                    d.bit_cnt = `RUNIN_LAST;
                    if (q.ld_std) begin
                        d.start_bit = `START_625;
                    end else begin
                        d.start_bit = q.ld_sys ? `START_525C : `START_525B;
                    end
                    d.sst = S_RUNIN;
                end
            end
            S_RUNIN, S_DATA: begin
                if (q.bit_tmr != 6'h0) begin
                    d.bit_tmr = q.bit_tmr - 6'h1;
                end else begin
                    d.bit_tmr = q.bit_per - 6'h1;
                    if (q.bit_cnt != 9'h0) begin
                        d.bit_cnt = q.bit_cnt - 9'h1;
                    end else if (q.sst == S_RUNIN) begin
                        d.bit_cnt = q.start_bit;
                        d.sst = S_DATA;
                    end else begin
                        d.sst = S_IDLE;
                    end
                end
            end
            default: d.sst = S_IDLE;
        endcase
        // Raised-cosine position; reverses in place if a bit flips mid-edge
        if (nbit && q.pos != 6'(`TTX_EDGE_CYC - 1)) begin
            d.pos = q.pos + 6'h1;
        end else if (!nbit && q.pos != 6'h0) begin
            d.pos = q.pos - 6'h1;
        end

        // only the low six bits are compared after the preamble
        if (w_valid && w_take) begin
            case (q.pst)
                P_IDLE: begin
                    if (w == `PRE_ZERO) begin
                        d.pst = P_PRE1;
                    end
                end
                P_PRE1: begin
                    if (w == `PRE_ONES) begin
                        d.pst = P_PRE2;
                    end else if (w != `PRE_ZERO) begin
                        d.pst = P_IDLE;
                    end
                end
                P_PRE2: d.pst = (w == `PRE_ONES) ? P_DID : P_IDLE;
                P_DID: begin
                    d.pst = P_BLK;
                    if (w[5:0] == `DID_TTX) begin
                        d.is_ttx = 1'b1;
                        d.pend = 1'b0;
                    end else if (w[5:0] == `DID_PHINC) begin
                        d.is_ttx = 1'b0;
                    end else begin
                        d.pst = P_IDLE;
                    end
                end
                P_BLK: begin
                    d.idx = 7'h0;
                    d.pst = (w[5:0] == `BLK_ONE) ? P_CNT : P_IDLE;
                end
                P_CNT: d.pst = P_PAY;
                P_PAY: begin
                    d.idx = q.idx + 7'h1;
                    d.tail = 2'h0;
                    if (q.is_ttx) begin
                        d.load[7'(`TTX_NIB - 1) - q.idx] = w[3:0];
                        if (q.idx == 7'h0) begin
                            d.ld_std = w[`STD_BIT];
                            d.ld_sys = w[`SYS_BIT];
                        end
                        if (q.idx == 7'(`TTX_NIB - 1)) begin
                            d.pst = P_TAIL;
                        end
                    end else begin
                        if (q.idx >= `PHINC_SKIP) begin
                            d.sub_acc = {q.sub_acc[27:0], w[3:0]};
                        end
                        if (q.idx == `PHINC_LAST) begin
                            d.pst = P_TAIL;
                        end
                    end
                end
                P_TAIL: begin
                    d.tail = q.tail + 2'h1;
                    if (!q.is_ttx) begin
                        d.sub_out = q.sub_acc;
                        d.sub_vld = 1'b1;
                        d.pst = P_IDLE;
                    end else if (q.tail == `TTX_TAIL_LAST) begin
                        d.pend = 1'b1;
                        d.pst = P_IDLE;
                    end
                end
                default: d.pst = P_IDLE;
            endcase
        end

        if (power_down) begin
            d.dac = '0;
        end else begin
            if (pix_valid) begin
                d.y_r = y_in;
                d.cb_r = cb_in;
                d.cr_r = cr_in;
                d.chroma_r = chroma_in;
                d.sync_r = sync_tip;
            end
            for (int i = 0; i < 4; i++) begin
                d.dac[i] = gated[i];
            end
        end

        if (int_rst) begin
            s1 = d.rst_s1;
            s2 = d.rst_s2;
            cnt = d.rst_cnt;
            d = '0;
            d.pst = P_IDLE;
            d.sst = S_IDLE;
            d.rst_s1 = s1;
            d.rst_s2 = s2;
            d.rst_cnt = cnt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            // Synchroniser idles at the released pin level, so no false pin reset follows
            q.rst_s1 <= 1'b1;
            q.rst_s2 <= 1'b1;
            q.pst <= P_IDLE;
            q.sst <= S_IDLE;
        end else begin
            q <= d;
        end
    end

    assign luma_pin = q.dac[0];
    assign chroma_pin = q.dac[1];
    assign first_composite_pin = q.dac[2];
    assign second_composite_pin = q.dac[3];
    assign subcarrier_increment = q.sub_out;
    assign subcarrier_inc_valid = q.sub_vld;
    assign ctrl_if_active = q.ctrl_active;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_pd_zero_dacs: assert property (power_down |=> luma_pin == 10'h0 && chroma_pin == 10'h0
        && first_composite_pin == 10'h0 && second_composite_pin == 10'h0)
        else $error("power-down did not zero the DACs");
    a_dac_enable_off: assert property (!power_down && !dac_en[3] |=> second_composite_pin == 10'h0)
        else $error("disabled channel still driven");
    a_ttx_hides_pix: assert property (!power_down && !int_rst && dac_en[0] && ttx_on
        && out_mode == M_YC |=> luma_pin == $past(lvl))
        else $error("teletext line shows pixel data");
    a_runin_start: assert property ($rose(ttx_on) |-> q.sst == S_RUNIN && q.bit_cnt == 9'h00f)
        else $error("run-in does not open with 16 bits");
    a_sysb_high: assert property (!q.lat_sys && q.pos == 6'd39 |-> lvl == `TTX_HI_B)
        else $error("system B one level wrong");
    a_sysc_high: assert property (q.lat_sys && q.pos == 6'd39 |-> lvl == `TTX_HI_C)
        else $error("system C one level wrong");
    a_edge_ramp: assert property (!int_rst && nbit && q.pos < 6'd39 |=> q.pos == $past(q.pos) + 6'h1)
        else $error("edge ramp did not advance");
    a_start_525b: assert property (q.sst == S_RUNIN && !int_rst && q.bit_tmr == 6'h0
        && q.bit_cnt == 9'h0 && q.start_bit == 9'h117 |=> q.sst == S_DATA && q.bit_cnt == 9'd279)
        else $error("525 system B start bit wrong");
    a_rgb_compat_clr: assert property (!power_down && !int_rst && out_mode == M_RGB && dac_en[2]
        && !connector_compat_bit && !ttx_on |=> first_composite_pin == $past(comp_v))
        else $error("compat-clear routing wrong");
    a_rgb_compat_set: assert property (!power_down && !int_rst && out_mode[1] && dac_en[0]
        && connector_compat_bit |=> luma_pin == $past(comp_v))
        else $error("compat-set routing wrong");
    a_reset_pin_len: assert property (q.rst_cnt == 3'h4 |=> !ctrl_if_active)
        else $error("pin reset did not idle control port");
    a_phinc_pulse: assert property (subcarrier_inc_valid |=> !subcarrier_inc_valid)
        else $error("increment strobe longer than one cycle");

    c_ttx_line: cover property ($rose(ttx_on) ##[1:600] q.sst == S_DATA);
    c_phinc_rx: cover property (subcarrier_inc_valid);
    c_rgb_compat: cover property (out_mode == M_RGB_SOG && connector_compat_bit && !power_down);
    c_fifo_full: cover property (!anc_ready);
endmodule

// *** teletext_router_map.svh ***
`ifndef TELETEXT_ROUTER_MAP_SVH
`define TELETEXT_ROUTER_MAP_SVH

// Timing
`define CLK_PERIOD_PS 5000
`define TTX_EDGE_NS 200
`define TTX_EDGE_CYC ((`TTX_EDGE_NS * 1000) / `CLK_PERIOD_PS)
`define TTX_EDGE_STEPS 8
`define TTX_STEP_CYC (`TTX_EDGE_CYC / `TTX_EDGE_STEPS)
`define TTX_BIT_B_NS 145
`define TTX_BIT_C_NS 175
`define TTX_BIT_B_CYC ((`TTX_BIT_B_NS * 1000) / `CLK_PERIOD_PS)
`define TTX_BIT_C_CYC ((`TTX_BIT_C_NS * 1000) / `CLK_PERIOD_PS)
`define RST_PIN_CYC 3'h4

// Ancillary packet framing
`define PRE_ZERO 8'h00
`define PRE_ONES 8'hff
`define DID_TTX 6'h34
`define DID_PHINC 6'h35
`define BLK_ONE 6'h01
`define STD_BIT 5
`define SYS_BIT 4
`define TTX_NIB 86
`define TTX_BITS 344
`define PHINC_SKIP 7'h04
`define PHINC_LAST 7'h0b
`define TTX_TAIL_LAST 2'h2

// Serialiser
`define RUNIN_PAT 16'h5555
`define RUNIN_LAST 9'h00f
`define START_625 9'h157
`define START_525B 9'h117
`define START_525C 9'h10f

// Levels, in DAC codes; CLAMP_MIN in 8-bit pixel codes
`define TTX_LO 10'h0f0
`define TTX_HI_B 10'h262
`define TTX_HI_C 10'h278
`define CHROMA_ZERO 14'sh0200
`define CLAMP_MIN 8'h10

`endif

// *** teletext_router_pkg.sv ***
package teletext_router_pkg;
`include "teletext_router_map.svh"

typedef enum logic [7:0] {
    P_IDLE = 8'h01, P_PRE1 = 8'h02, P_PRE2 = 8'h04, P_DID = 8'h08,
    P_BLK = 8'h10, P_CNT = 8'h20, P_PAY = 8'h40, P_TAIL = 8'h80
} parse_st_t;

typedef enum logic [2:0] {
    S_IDLE = 3'h1, S_RUNIN = 3'h2, S_DATA = 3'h4
} ser_st_t;

typedef enum logic [1:0] {
    M_YC = 2'h0, M_YUV = 2'h1, M_RGB = 2'h2, M_RGB_SOG = 2'h3
} out_mode_t;

typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [2:0] rst_cnt;
    logic ctrl_active;
    parse_st_t pst;
    logic is_ttx;
    logic [6:0] idx;
    logic [1:0] tail;
    logic [(`TTX_NIB)-1:0][3:0] load;
    logic ld_std;
    logic ld_sys;
    logic pend;
    logic [31:0] sub_acc;
    logic [31:0] sub_out;
    logic sub_vld;
    logic [(`TTX_BITS)-1:0] play;
    ser_st_t sst;
    logic [8:0] bit_cnt;
    logic [8:0] start_bit;
    logic [5:0] bit_tmr;
    logic [5:0] bit_per;
    logic [5:0] pos;
    logic lat_sys;
    logic [7:0] y_r;
    logic [7:0] cb_r;
    logic [7:0] cr_r;
    logic [9:0] chroma_r;
    logic sync_r;
    logic [3:0][9:0] dac;
} core_st_t;

endpackage

// *** anc_source.sv ***
`timescale 1ns/1ps
module anc_source (
    input wire logic sys_clk,
    input wire logic anc_ready,
    output logic [7:0] anc_word,
    output logic anc_valid
);
    initial begin
        anc_word = 8'h00;
        anc_valid = 1'b0;
    end

    // Word is held until taken; afterwards the bus shows the inverse so stale data never matches
    task automatic put(input logic [7:0] w);
        int n;
        @(negedge sys_clk);
        anc_word = w;
        anc_valid = 1'b1;
        n = 0;
        while (anc_ready !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        anc_valid = 1'b0;
        anc_word = ~w;
    endtask

    // Parity bits are set to a mix of values; the receiver must ignore them
    task automatic head(input logic [5:0] id);
        put(8'h00);
        put(8'hff);
        put(8'hff);
        put({2'b10, id});
        put(8'h41);
        put(8'h96);
    endtask

    task automatic send_ttx(input logic std, input logic sys, input logic [343:0] b);
        head(6'h34);
        for (int i = 0; i < 86; i++) begin
            put({2'b11, (i == 0) ? {std, sys} : 2'b00, b[343 - 4 * i -: 4]});
        end
        put(8'h00);
        put(8'h00);
        put(8'h5a);
    endtask

    task automatic send_phinc(input logic [31:0] v);
        head(6'h35);
        for (int i = 0; i < 4; i++) begin
            put(8'hcf);
        end
        for (int i = 0; i < 8; i++) begin
            put({2'b01, (i < 2) ? 2'b11 : 2'b00, v[31 - 4 * i -: 4]});
        end
        put(8'hff);
    endtask
endmodule

// *** teletext_router_tb_top.sv ***
`timescale 1ns/1ps
module teletext_router_tb_top;
    logic sys_clk, rstn, reset_pin_n, soft_reset, power_down, connector_compat_bit;
    logic pal_mode, add_sync, sync_tip, sav_pulse, pix_valid, anc_valid, anc_ready;
    logic [3:0] dac_en;
    logic [1:0] out_mode;
    logic [7:0] anc_word, y_in, cb_in, cr_in;
    logic [9:0] chroma_in, luma_pin, chroma_pin, first_composite_pin, second_composite_pin;
    logic ttx_on, subcarrier_inc_valid, ctrl_if_active;
    logic [31:0] subcarrier_increment;
    wire logic [9:0] pins [4];
    int bad_count = 0;
    int n_checks = 0;

    assign pins[0] = luma_pin;
    assign pins[1] = chroma_pin;
    assign pins[2] = first_composite_pin;
    assign pins[3] = second_composite_pin;

    teletext_router dut_u (.*);
    anc_source src_u (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic setpix(input logic [7:0] y, input logic [7:0] c, input logic p);
        @(negedge sys_clk);
        y_in = y;
        cb_in = c;
        cr_in = c;
        pal_mode = p;
    endtask

    task automatic setm(input logic [1:0] m, input logic c, output logic [9:0] s [4]);
        @(negedge sys_clk);
        out_mode = m;
        connector_compat_bit = c;
        repeat (6) @(posedge sys_clk);
        #1;
        s = pins;
    endtask

    task automatic t_route();
        logic [9:0] yc [4], r0 [4], r1 [4], yuv [4];
        @(negedge sys_clk);
        cr_in = 8'ha0;
        setm(2'h0, 1'b0, yc);
        setm(2'h2, 1'b0, r0);
        setm(2'h2, 1'b1, r1);
        setm(2'h1, 1'b0, yuv);
        chk("yc composite copies", yc[3], yc[2]);
        chk("rgb0 composite", r0[2], yc[2]);
        chk("rgb1 composite", r1[0], yc[2]);
        chk("rgb1 red", r1[1], r0[3]);
        chk("rgb1 blue", r1[3], r0[1]);
        chk("rgb1 green", r1[2], r0[0]);
        chk("yuv composite", yuv[0], yc[2]);
        @(negedge sys_clk) sync_tip = 1'b1;
        setm(2'h3, 1'b0, r0);
        chk("sync on green", r0[0], 10'h000);
        chk("sync keeps composite", r0[2], yc[2]);
        @(negedge sys_clk) sync_tip = 1'b0;
    endtask

    task automatic t_clamp();
        logic [9:0] a [4], b [4];
        for (int p = 0; p < 2; p++) begin
            setpix(8'h00, 8'h00, p[0]);
            setm(2'h1, 1'b0, a);
            setpix(8'h10, 8'h10, p[0]);
            setm(2'h1, 1'b0, b);
            for (int j = 1; j < 4; j++) begin
                chk("yuv clamp", b[j], a[j]);
            end
        end
    endtask

    task automatic t_power();
        logic [9:0] base [4], s [4];
        setpix(8'h80, 8'h60, 1'b0);
        setm(2'h0, 1'b0, base);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            dac_en = 4'hf ^ (4'h1 << i);
            setm(2'h0, 1'b0, s);
            for (int j = 0; j < 4; j++) begin
                chk("dac enable", s[j], (i == j) ? 10'h000 : base[j]);
            end
        end
        @(negedge sys_clk);
        dac_en = 4'hf;
        power_down = 1'b1;
        setm(2'h0, 1'b0, s);
        for (int j = 0; j < 4; j++) begin
            chk("power down", s[j], 10'h000);
        end
        @(negedge sys_clk);
        power_down = 1'b0;
        soft_reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("soft reset ctrl", ctrl_if_active, 1'b0);
        chk("soft reset dac", luma_pin, 10'h000);
        @(negedge sys_clk);
        soft_reset = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("soft reset end", ctrl_if_active, 1'b1);
    endtask

    task automatic t_phinc(input logic [31:0] v);
        logic [31:0] got;
        int w;
        got = '0;
        w = 0;
        fork
            src_u.send_phinc(v);
            begin
                while (subcarrier_inc_valid !== 1'b1 && w < 2000) begin
                    @(posedge sys_clk) #1;
                    w++;
                end
                got = subcarrier_increment;
            end
        join
        chk("subcarrier increment", got, v);
    endtask

    task automatic t_ttx(input logic std, input logic sys, input int len, input logic [9:0] hi);
        int n, w;
        n = 0;
        w = 0;
        setpix(8'hc0, 8'h60, 1'b0);
        src_u.send_ttx(std, sys, '1);
        @(negedge sys_clk) sav_pulse = 1'b1;
        @(negedge sys_clk) sav_pulse = 1'b0;
        while (ttx_on !== 1'b1 && w < 3) begin
            @(posedge sys_clk) #1;
            w++;
        end
        chk("teletext start", ttx_on, 1'b1);
        while (ttx_on === 1'b1 && n < 20000) begin
            if (n == 14)
                chk("run-in first bit", luma_pin, 10'h0f0);
            if (n == len - 60) begin
                chk("teletext one luma", luma_pin, hi);
                chk("teletext one comp", first_composite_pin, hi);
            end
            @(posedge sys_clk) #1;
            n++;
        end
        chk("teletext length", n, len);
    endtask

    task automatic t_nopend();
        int hits;
        hits = 0;
        @(negedge sys_clk) sav_pulse = 1'b1;
        @(negedge sys_clk) sav_pulse = 1'b0;
        repeat (50) begin
            @(posedge sys_clk) #1;
            hits += (ttx_on !== 1'b0);
        end
        chk("no packet no teletext", hits, 0);
    endtask

    task automatic t_pin();
        int bad;
        bad = 0;
        // Three low cycles are one short of the documented minimum
        @(negedge sys_clk) reset_pin_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        reset_pin_n = 1'b1;
        repeat (12) begin
            @(posedge sys_clk) #1;
            bad += (ctrl_if_active !== 1'b1);
        end
        chk("short pin pulse", bad, 0);
        @(negedge sys_clk) reset_pin_n = 1'b0;
        repeat (12) @(negedge sys_clk);
        chk("pin reset", ctrl_if_active, 1'b0);
        reset_pin_n = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk("pin reset end", ctrl_if_active, 1'b1);
    endtask

    initial begin
        rstn = 1'b0;
        {reset_pin_n, soft_reset, power_down, connector_compat_bit} = 4'h8;
        {pal_mode, add_sync, sync_tip, sav_pulse, pix_valid} = 5'h01;
        dac_en = 4'hf;
        out_mode = 2'h0;
        {y_in, cb_in, cr_in} = 24'h806060;
        chroma_in = 10'h250;
        repeat (10) @(negedge sys_clk);
        chk("reset ctrl", ctrl_if_active, 1'b0);
        chk("reset ready", anc_ready, 1'b1);
        chk("reset dac", luma_pin, 10'h000);
        repeat (6) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("ctrl after reset", ctrl_if_active, 1'b1);
        t_route();
        t_clamp();
        t_power();
        t_phinc(32'h1234_5678);
        t_ttx(1'b1, 1'b0, 360 * 29, 10'h262);
        t_ttx(1'b0, 1'b0, 296 * 29, 10'h262);
        t_ttx(1'b0, 1'b1, 288 * 35, 10'h278);
        t_nopend();
        t_pin();
        end_sim();
    end

    // Three teletext lines dominate the run at about 30000 cycles
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
endmodule
